// File: logic/hcr_receiver.sv
// module: hopping code receiver, table lookup, decryption, window check and learning
`timescale 1ns/1ps
module hcr_receiver #(
    parameter int DEPTH = 8,
    parameter int ROUNDS = 64,
    parameter logic [63:0] MFR_KEY = 64'h0123_4567_89AB_CDEF // arbitrary
) (
    input wire logic mclk, // system clock, 10 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic rx_valid, // code word present, taken when rx_ready
    input wire hcr_pkg::hcr_word_s rx_word, // demodulated code word
    input wire logic learn_mode, // level: learn new transmitters
    output logic rx_ready, // idle, next word may be offered
    output logic func_valid, // one-cycle: function to execute
    output hcr_pkg::hcr_func_s func, // serial, buttons, status of it
    output logic rx_reject, // one-cycle: serial not learned
    output logic learn_ok, // one-cycle: transmitter stored
    output logic learn_fail // one-cycle: learn word failed discrimination check
);
    import hcr_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SCAN = 3'b001,
        ST_MATCH = 3'b010,
        ST_KEY_LO = 3'b011,
        ST_KEY_HI = 3'b100,
        ST_DECRYPT = 3'b101,
        ST_CHECK = 3'b110,
        ST_WRITE = 3'b111
    } hcr_state_e;

    hcr_state_e state;
    hcr_state_e next_state;
    hcr_word_s word;
    hcr_plain_s plain;
    logic lrn;
    logic [AW-1:0] idx;
    logic [AW-1:0] hit_idx;
    logic [KEY_W-1:0] key;
    logic [CNT_W-1:0] stored;
    logic pend_valid;
    logic [AW-1:0] pend_idx;
    logic [CNT_W-1:0] pend_cnt;
    logic lstage;
    logic [SER_W-1:0] lser;
    logic [CNT_W-1:0] lcnt;
    logic [AW-1:0] lptr;
    logic launch;
    logic next_launch;
    hcr_entry_s rd_data;
    hcr_entry_s wr_entry;
    logic [HOP_W-1:0] c_dout;
    logic c_done;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire hit = rd_data.used && (rd_data.serial == word.serial);
    wire disc_ok = (plain.disc == word.serial[DISC_LSB +: DISC_W]);
    wire [CNT_W-1:0] diff = plain.cnt - stored;
    wire in_single = (diff != '0) && (diff <= SINGLE_WIN);
    wire in_double = (diff > SINGLE_WIN) && (diff <= DOUBLE_WIN);
    wire in_blocked = !in_single && !in_double;
    wire seq_ok = pend_valid && (pend_idx == hit_idx)
        && (plain.cnt == pend_cnt + CNT_STEP);
    wire learn_seq = lstage && (lser == word.serial)
        && (plain.cnt == lcnt + CNT_STEP);
    wire exec_go = !lrn && (in_single || (in_double && seq_ok));
    wire wr_en = (state == ST_WRITE);
    wire [AW-1:0] wr_addr = lrn ? lptr : hit_idx;
    wire [HOP_W-1:0] c_din = (state == ST_KEY_LO) ? {KGEN_LO_TAG, word.serial}
        : (state == ST_KEY_HI) ? {KGEN_HI_TAG, word.serial} : word.hop;
    wire [KEY_W-1:0] c_key = (state == ST_DECRYPT) ? key : MFR_KEY;
    assign wr_entry = '{used: 1'b1, serial: word.serial, cnt: plain.cnt, key: key};

    hcr_table #(.DEPTH(DEPTH)) u_table (
        .mclk(mclk),
        .arst_n(arst_n),
        .rd_addr(idx),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_entry)
    );

    hcr_cipher #(.ROUNDS(ROUNDS)) u_cipher (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(launch),
        .key(c_key),
        .din(c_din),
        .dout(c_dout),
        .done(c_done)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_launch = 1'b0;
        case (state)
            ST_IDLE: begin
                if (rx_valid) begin
                    next_state = learn_mode ? ST_KEY_LO : ST_SCAN;
                    next_launch = learn_mode;
                end
            end
            ST_SCAN: next_state = ST_MATCH;
            ST_MATCH: begin
                if (hit) begin
                    next_state = ST_DECRYPT;
                    next_launch = 1'b1;
                end else if (idx == LAST) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_SCAN;
                end
            end
            ST_KEY_LO: begin
                if (c_done) begin
                    next_state = ST_KEY_HI;
                    next_launch = 1'b1;
                end
            end
            ST_KEY_HI: begin
                if (c_done) begin
                    next_state = ST_DECRYPT;
                    next_launch = 1'b1;
                end
            end
            ST_DECRYPT: if (c_done) next_state = ST_CHECK;
            ST_CHECK: begin
                if (disc_ok && ((lrn && learn_seq) || exec_go)) begin
                    next_state = ST_WRITE;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            launch <= 1'b0;
            rx_ready <= 1'b1;
        end else begin
            state <= next_state;
            launch <= next_launch;
            rx_ready <= (next_state == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // word capture, table scan and key
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            word <= '0;
            lrn <= 1'b0;
            idx <= '0;
        end else if (state == ST_IDLE && rx_valid) begin
            word <= rx_word;
            lrn <= learn_mode;
            idx <= '0;
        end else if (state == ST_MATCH && !hit && idx != LAST) begin
            idx <= idx + AW'(1);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            key <= '0;
            stored <= '0;
            hit_idx <= '0;
            plain <= '0;
        end else begin
            if (state == ST_MATCH && hit) begin
                key <= rd_data.key;
                stored <= rd_data.cnt;
                hit_idx <= idx;
            end
            if (state == ST_KEY_LO && c_done) key[31:0] <= c_dout;
            if (state == ST_KEY_HI && c_done) key[63:32] <= c_dout;
            if (state == ST_DECRYPT && c_done) plain <= c_dout;
        end
    end

    // ------------------------------------------------------------
    // resync pending word and learn buffer
    // ------------------------------------------------------------
    // one pending word only: a newer double-window word replaces it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_valid <= 1'b0;
            pend_idx <= '0;
            pend_cnt <= '0;
        end else if (state == ST_WRITE && !lrn) begin
            pend_valid <= 1'b0;
        end else if (state == ST_CHECK && disc_ok && !lrn && in_double && !seq_ok) begin
            pend_valid <= 1'b1;
            pend_idx <= hit_idx;
            pend_cnt <= plain.cnt;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lstage <= 1'b0;
            lser <= '0;
            lcnt <= '0;
            lptr <= '0;
        end else if (!learn_mode || (state == ST_WRITE && lrn)) begin
            lstage <= 1'b0;
            if (state == ST_WRITE && lrn) lptr <= lptr + AW'(1);
        end else if (state == ST_CHECK && lrn && disc_ok && !learn_seq) begin
            lstage <= 1'b1;
            lser <= word.serial;
            lcnt <= plain.cnt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            func_valid <= 1'b0;
            func <= '0;
            rx_reject <= 1'b0;
            learn_ok <= 1'b0;
            learn_fail <= 1'b0;
        end else begin
            func_valid <= wr_en && !lrn;
            if (wr_en && !lrn) func <= '{serial: word.serial, btn: plain.btn, status: word.status};
            rx_reject <= (state == ST_MATCH) && !hit && (idx == LAST);
            learn_ok <= wr_en && lrn;
            learn_fail <= (state == ST_CHECK) && lrn && !disc_ok;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_commit;
        state == ST_WRITE ##1 func_valid;
    endsequence

    sequence s_drop;
        state == ST_IDLE ##1 !func_valid;
    endsequence

    a_unknown_reject: assert property (
        state == ST_MATCH && !hit && idx == LAST |=> state == ST_IDLE && rx_reject)
        else $error("unlearned serial not rejected");
    a_scan_first: assert property (
        state == ST_DECRYPT && $past(state) != ST_DECRYPT && !lrn |-> $past(state) == ST_MATCH)
        else $error("decryption started without table lookup");
    a_disc_gate: assert property (
        state == ST_CHECK && !disc_ok |=> s_drop)
        else $error("bad discrimination bits accepted");
    a_cnt_source: assert property (
        state == ST_DECRYPT && c_done |=> plain == $past(c_dout))
        else $error("counter not taken from decrypted block");
    a_single_exec: assert property (
        state == ST_CHECK && disc_ok && !lrn && in_single |=> s_commit)
        else $error("single window word not executed");
    a_double_wait: assert property (
        state == ST_CHECK && disc_ok && !lrn && in_double && !seq_ok
        |=> state == ST_IDLE && pend_valid && pend_cnt == $past(plain.cnt) ##1 !func_valid)
        else $error("double window word executed too early");
    a_blocked_drop: assert property (
        state == ST_CHECK && !lrn && in_blocked |=> s_drop)
        else $error("blocked counter executed");
    a_store_cnt: assert property (
        func_valid |-> $past(wr_en) && $past(wr_entry.cnt) == $past(plain.cnt)
        && $past(wr_addr) == $past(hit_idx))
        else $error("executed counter not written back");
    a_keygen_path: assert property (
        state == ST_DECRYPT && $past(state) != ST_DECRYPT && lrn |-> $past(state) == ST_KEY_HI)
        else $error("learn decryption without key generation");
    a_learn_seq: assert property (
        learn_ok |-> $past(lstage) && $past(plain.cnt) == $past(lcnt) + CNT_STEP)
        else $error("learned without sequential second word");
    // a word offered while busy is not queued, so ready must stay low
    a_busy_ready: assert property (
        state != ST_IDLE |-> !rx_ready)
        else $error("ready raised while a word is in work");
    a_key_fetch: assert property (
        state == ST_MATCH && hit |=> key == $past(rd_data.key))
        else $error("stored key not fetched");
endmodule : hcr_receiver

// File: logic/hcr_pkg.sv
// package: field layout, window limits and types of the hopping code receiver
//
// What this block does
// - a transmitter that is not in the learned table never triggers a function.
// - for a normal word, the cleartext serial number is looked up in the table before decryption; learn words skip the lookup.
// - the hopping part is decrypted with the stored key, and the counter is used only if the discrimination bits match.
// - the counter is taken only from the decrypted part, never from the cleartext.
// - a counter 1 to 16 ahead of the stored one executes at once and is stored.
// - a counter further ahead, up to 32K, executes only after a second word with the next counter.
// - a counter outside both windows, including one already used, is dropped without any answer.
// - every executed word writes its counter back to the table, moving the windows forward.
// - when learning, the key is generated from the received serial number.
// - learning needs two good words with sequential counters, then stores serial, counter and key.
// - once learned, the key is fetched from the table for each normal word.
package hcr_pkg;
    localparam int SER_W = 28;
    localparam int CNT_W = 16;
    localparam int KEY_W = 64;
    localparam int BTN_W = 4;
    localparam int DISC_W = 12;
    localparam int STAT_W = 2;
    localparam int HOP_W = 32;
    // window limits as counter distances
    localparam logic [CNT_W-1:0] SINGLE_WIN = 16'h0010;
    localparam logic [CNT_W-1:0] DOUBLE_WIN = 16'h8000;
    localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
    // key generation inputs: tag nibble above the serial number
    localparam logic [3:0] KGEN_LO_TAG = 4'h2;
    localparam logic [3:0] KGEN_HI_TAG = 4'h6;
    // discrimination value expected: low serial bits from this position
    localparam int DISC_LSB = 0;

    // received code word, fixed part first
    typedef struct packed {
        logic [STAT_W-1:0] status;
        logic [BTN_W-1:0] btn;
        logic [SER_W-1:0] serial;
        logic [HOP_W-1:0] hop;
    } hcr_word_s;

    typedef struct packed {
        logic [BTN_W-1:0] btn;
        logic [DISC_W-1:0] disc;
        logic [CNT_W-1:0] cnt;
    } hcr_plain_s;

    typedef struct packed {
        logic used;
        logic [SER_W-1:0] serial;
        logic [CNT_W-1:0] cnt;
        logic [KEY_W-1:0] key;
    } hcr_entry_s;

    typedef struct packed {
        logic [SER_W-1:0] serial;
        logic [BTN_W-1:0] btn;
        logic [STAT_W-1:0] status;
    } hcr_func_s;
endpackage : hcr_pkg

// File: logic/hcr_cipher.sv
// module: iterative nonlinear block decryptor, also used for key generation
`timescale 1ns/1ps
module hcr_cipher #(
    parameter int ROUNDS = 64,
    parameter logic [31:0] NLF = 32'h3A5C_742E
) (
    input wire logic mclk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic start, // one-cycle launch
    input wire logic [hcr_pkg::KEY_W-1:0] key, // crypt key
    input wire logic [hcr_pkg::HOP_W-1:0] din, // block in
    output logic [hcr_pkg::HOP_W-1:0] dout, // block out
    output logic done // one-cycle finish pulse
);
    import hcr_pkg::*;
    localparam int CW = $clog2(ROUNDS + 1);
    localparam logic [CW-1:0] LAST = CW'(ROUNDS - 1);

    logic [CW-1:0] rnd;
    logic run;
    logic [KEY_W-1:0] k;
    wire [4:0] tap = {dout[30], dout[25], dout[19], dout[8], dout[0]};
    wire new_bit = dout[31] ^ dout[15] ^ k[15] ^ NLF[tap];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rnd <= '0;
            run <= 1'b0;
            done <= 1'b0;
            dout <= '0;
            k <= '0;
        end else if (start) begin
            rnd <= '0;
            run <= 1'b1;
            done <= 1'b0;
            dout <= din;
            k <= key;
        end else if (run) begin
            dout <= {dout[30:0], new_bit};
            k <= {k[KEY_W-2:0], k[KEY_W-1]};
            rnd <= rnd + CW'(1);
            run <= (rnd != LAST);
            done <= (rnd == LAST);
        end else begin
            done <= 1'b0;
        end
    end
endmodule : hcr_cipher

// File: logic/hcr_table.sv
// module: learned transmitter table, registered read
`timescale 1ns/1ps
module hcr_table #(
    parameter int DEPTH = 8
) (
    input wire logic mclk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [$clog2(DEPTH)-1:0] rd_addr, // read index
    output hcr_pkg::hcr_entry_s rd_data, // entry, one cycle after address
    input wire logic wr_en, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] wr_addr, // write index
    input wire hcr_pkg::hcr_entry_s wr_data // entry to store
);
    import hcr_pkg::*;
    hcr_entry_s mem [DEPTH];

    // only the used flag needs a reset value; an empty slot never matches
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    mem[g] <= '0;
                end else if (wr_en && (wr_addr == g)) begin
                    mem[g] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : hcr_table

// File: verification/hcr_tx_model.sv
// partner model: code hopping transmitter that builds the receiver's test words
`timescale 1ns/1ps
module hcr_tx_model #(
    parameter int ROUNDS = 64,
    parameter logic [63:0] MFR_KEY = 64'h0123_4567_89AB_CDEF, // arbitrary
    parameter logic [31:0] NLF = 32'h3A5C_742E // arbitrary
) (
    input wire logic [hcr_pkg::SER_W-1:0] serial, // serial number of this unit
    input wire logic [hcr_pkg::CNT_W-1:0] cnt, // sync counter to encrypt
    input wire logic [hcr_pkg::BTN_W-1:0] btn, // buttons, encrypted copy
    input wire logic [hcr_pkg::BTN_W-1:0] clr_btn, // buttons, cleartext copy
    input wire logic [hcr_pkg::STAT_W-1:0] status, // status bits
    input wire logic bad_disc, // send wrong discrimination bits
    output hcr_pkg::hcr_word_s word // finished code word
);
    import hcr_pkg::*;

    // ----------------------------------------
    // cipher steps
    // ----------------------------------------
    function automatic logic [HOP_W-1:0] hcr_dec(input logic [HOP_W-1:0] blk,
                                                 input logic [KEY_W-1:0] key);
        logic [HOP_W-1:0] x;
        logic [KEY_W-1:0] k;
        x = blk;
        k = key;
        for (int r = 0; r < ROUNDS; r++) begin
            x = {x[30:0], x[31] ^ x[15] ^ k[15] ^ NLF[{x[30], x[25], x[19], x[8], x[0]}]};
            k = {k[62:0], k[63]};
        end
        return x;
    endfunction : hcr_dec

    // undoes the rounds last first, so the key starts rotated ROUNDS-1 places, as in the last round
    function automatic logic [HOP_W-1:0] hcr_enc(input logic [HOP_W-1:0] blk,
                                                 input logic [KEY_W-1:0] key);
        logic [HOP_W-1:0] x;
        logic [KEY_W-1:0] k;
        x = blk;
        k = key;
        for (int r = 1; r < ROUNDS; r++) begin
            k = {k[62:0], k[63]};
        end
        for (int r = 0; r < ROUNDS; r++) begin
            x = {x[0] ^ x[16] ^ k[15] ^ NLF[{x[31], x[26], x[20], x[9], x[1]}], x[31:1]};
            k = {k[0], k[63:1]};
        end
        return x;
    endfunction : hcr_enc

    // ----------------------------------------
    // word assembly
    // ----------------------------------------
    logic [KEY_W-1:0] tx_key;
    logic [DISC_W-1:0] disc_val;
    logic [HOP_W-1:0] plain;

    assign tx_key = {hcr_dec({KGEN_HI_TAG, serial}, MFR_KEY), hcr_dec({KGEN_LO_TAG, serial}, MFR_KEY)};
    assign disc_val = bad_disc ? ~serial[DISC_W-1:0] : serial[DISC_W-1:0];
    assign plain = {btn, disc_val, cnt};
    assign word = {status, clr_btn, serial, hcr_enc(plain, tx_key)};
endmodule : hcr_tx_model

// File: verification/tb_top.sv
// testbench: drives code words into the receiver and scores its answers
`timescale 1ns/1ps
module tb_top;
    import hcr_pkg::*;
    localparam int ROUNDS = 8;
    localparam int DEPTH = 4;
    localparam logic [63:0] MFR_KEY = 64'h5A5A_1234_C3C3_9876; // arbitrary
    localparam int TMO = 4*(ROUNDS+4)+2*DEPTH+8;
    localparam logic [27:0] SA = 28'h0AB_C123;
    localparam logic [27:0] SB = 28'h7F0_5E61;
    localparam logic [27:0] SC = 28'h123_4567;
    typedef enum logic [2:0] {K_FUNC, K_REJ, K_LOK, K_LFAIL, K_NONE} hcr_kind_e;
    typedef struct packed {
        hcr_kind_e kind;
        hcr_func_s f;
    } hcr_exp_s;

    logic mclk, arst_n, rx_valid, learn_mode, rx_ready, func_valid, rx_reject, learn_ok;
    logic learn_fail, m_bad;
    hcr_word_s rx_word, m_word;
    hcr_func_s func;
    logic [SER_W-1:0] m_serial;
    logic [CNT_W-1:0] m_cnt, c;
    logic [BTN_W-1:0] m_btn, m_clr;
    logic [STAT_W-1:0] m_status;
    hcr_exp_s exp_q[$];
    hcr_exp_s e;
    int err_count = 0;
    int checks_done = 0;

    hcr_receiver #(.DEPTH(DEPTH), .ROUNDS(ROUNDS), .MFR_KEY(MFR_KEY)) i_hcr_receiver (
        .mclk(mclk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_word(rx_word),
        .learn_mode(learn_mode), .rx_ready(rx_ready), .func_valid(func_valid), .func(func),
        .rx_reject(rx_reject), .learn_ok(learn_ok), .learn_fail(learn_fail));
    hcr_tx_model #(.ROUNDS(ROUNDS), .MFR_KEY(MFR_KEY)) i_hcr_tx_model (
        .serial(m_serial), .cnt(m_cnt), .btn(m_btn), .clr_btn(m_clr), .status(m_status),
        .bad_disc(m_bad), .word(m_word));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // cleartext buttons inverted so only the decrypted copy can match
    task automatic send(input logic [27:0] s, input logic [15:0] cv, input logic [3:0] b,
                        input logic bad, input hcr_kind_e k);
        int n;
        m_serial = s;
        m_cnt = cv;
        m_btn = b;
        m_clr = ~b;
        m_bad = bad;
        m_status = 2'($urandom);
        if (k != K_NONE) begin
            exp_q.push_back(hcr_exp_s'({k, s, b, m_status}));
        end
        @(negedge mclk);
        rx_valid = 1'b1;
        rx_word = m_word;
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_word = ~rx_word;
        chk("ready while busy", rx_ready, 0);
        n = 0;
        while (rx_ready !== 1'b1 && n < TMO) begin
            @(negedge mclk);
            n++;
        end
        if (n >= TMO) begin
            err_count++;
            conclude();
        end
        repeat (2) @(negedge mclk);
    endtask : send

    // ----------------------------------------
    // clock, watchdog, monitor
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        conclude();
    end

    always @(negedge mclk) begin
        if (arst_n === 1'b1 && (func_valid | rx_reject | learn_ok | learn_fail) !== 1'b0) begin
            if (exp_q.size() == 0) begin
                chk("unexpected pulse", {func_valid, rx_reject, learn_ok, learn_fail}, 0);
            end else begin
                e = exp_q.pop_front();
                chk("answer kind", {func_valid, rx_reject, learn_ok, learn_fail}, 4'b1000 >> e.kind);
                if (e.kind == K_FUNC) begin
                    chk("function", func, e.f);
                end
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        rx_valid = 1'b0;
        rx_word = '0;
        learn_mode = 1'b0;
        void'($urandom(18374));
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        send(SA, 16'h0064, 4'h3, 1'b0, K_REJ);
        learn_mode = 1'b1;
        send(SA, 16'h0064, 4'h1, 1'b1, K_LFAIL);
        send(SA, 16'h0064, 4'h1, 1'b0, K_NONE);
        send(SA, 16'h0065, 4'h1, 1'b0, K_LOK);
        send(SB, 16'hFFFF, 4'h2, 1'b0, K_NONE);
        send(SB, 16'h0000, 4'h2, 1'b0, K_LOK);
        learn_mode = 1'b0;
        send(SC, 16'h0001, 4'h4, 1'b0, K_REJ);
        send(SA, 16'h0075, 4'h5, 1'b1, K_NONE);
        send(SA, 16'h0075, 4'h5, 1'b0, K_FUNC);
        send(SA, 16'h0075, 4'h5, 1'b0, K_NONE);
        send(SA, 16'h0086, 4'h6, 1'b0, K_NONE);
        send(SA, 16'h0087, 4'h6, 1'b0, K_FUNC);
        send(SA, 16'h8086, 4'h7, 1'b0, K_NONE);
        send(SA, 16'h8087, 4'h7, 1'b0, K_FUNC);
        send(SA, 16'h0089, 4'h8, 1'b0, K_NONE);
        send(SB, 16'h0100, 4'h9, 1'b0, K_NONE);
        send(SB, 16'h0102, 4'h9, 1'b0, K_NONE);
        send(SB, 16'h0103, 4'hA, 1'b0, K_FUNC);
        c = 16'h0103;
        for (int i = 0; i < 12; i++) begin
            c = c + 16'(1 + $urandom % 16);
            send(SB, c, 4'($urandom), 1'b0, K_FUNC);
        end
        repeat (4) @(negedge mclk);
        chk("pending answers", exp_q.size(), 0);
        conclude();
    end
endmodule : tb_top
